// file: boot_prog_pkg.sv
// constants and types shared by both ends of the self-programming link
package boot_prog_pkg;
   // -----------------------------------------------------------------
   // control/status register
   // -----------------------------------------------------------------
   localparam logic [7:0] CSR_OFFSET     = 8'h68;
   localparam logic [7:0] CSR_RESET      = 8'h00;
   localparam int         BIT_IRQ_EN     = 7;
   localparam int         BIT_RWW_BUSY   = 6;
   localparam int         BIT_REENABLE   = 4;
   localparam int         BIT_LOCK_SET   = 3;
   localparam int         BIT_PAGE_WRITE = 2;
   localparam int         BIT_PAGE_ERASE = 1;
   localparam int         BIT_PROG_EN    = 0;
   localparam logic [4:0] CMD_REENABLE   = 5'h11;
   localparam logic [4:0] CMD_LOCK_SET   = 5'h09;
   localparam logic [4:0] CMD_PAGE_WRITE = 5'h05;
   localparam logic [4:0] CMD_PAGE_ERASE = 5'h03;
   localparam logic [4:0] CMD_FILL       = 5'h01;
   // -----------------------------------------------------------------
   // flash geometry
   // -----------------------------------------------------------------
   localparam int         PAGE_W         = 9;
   localparam int         WORD_W         = 7;
   localparam int         PAGE_WORDS     = 128;
   localparam logic [8:0] RWW_PAGES      = 9'h1E0;
   localparam logic [15:0] BOOT_START_512  = 16'hFE00;
   localparam logic [15:0] BOOT_START_1024 = 16'hFC00;
   localparam logic [15:0] BOOT_START_2048 = 16'hF800;
   localparam logic [15:0] BOOT_START_4096 = 16'hF000;
   localparam logic [1:0] SEL_FUSE_LOW   = 2'h0;
   localparam logic [1:0] SEL_LOCK       = 2'h1;
   localparam logic [1:0] SEL_FUSE_EXT   = 2'h2;
   localparam logic [1:0] SEL_FUSE_HIGH  = 2'h3;
   localparam logic [7:0] LOCK_RESET     = 8'hFF;
   localparam logic [7:0] LOCK_WR_MASK   = 8'hC0;
   localparam logic [15:0] ERASED_WORD   = 16'hFFFF;
   // -----------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------
   localparam int         CLK_PERIOD_PS  = 4000;
   localparam longint     PROG_TIME_MIN_PS = 64'd3700000000;
   localparam longint     PROG_TIME_MAX_PS = 64'd4500000000;
   localparam int         PROG_CYCLES_MIN  =
      int'((PROG_TIME_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam int         PROG_CYCLES_MAX  = int'(PROG_TIME_MAX_PS / CLK_PERIOD_PS);
   localparam int         OP_CNT_W       = 20;
   localparam logic [2:0] STORE_WIN      = 3'h4;
   localparam logic [2:0] LOAD_WIN       = 3'h3;
   // -----------------------------------------------------------------
   // sequencer states
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_ARMED = 3'b010,
      ST_BUSY  = 3'b100
   } seq_state_t;
   // -----------------------------------------------------------------
   // software port of the core end
   // -----------------------------------------------------------------
   localparam logic [7:0] SW_CSR         = 8'h00;
   localparam logic [7:0] SW_POINTER     = 8'h04;
   localparam logic [7:0] SW_EXT_POINTER = 8'h08;
   localparam logic [7:0] SW_DATA        = 8'h0C;
   localparam logic [7:0] SW_ISSUE       = 8'h10;
   localparam logic [7:0] SW_LOAD_RESULT = 8'h14;
   localparam logic [7:0] SW_CORE_CTRL   = 8'h18;
   localparam logic [7:0] SW_STATUS      = 8'h1C;
endpackage : boot_prog_pkg

// file: boot_prog_if.sv
// link between the processor core and the self-programming controller
`timescale 1ns/1ps
interface boot_prog_if;
   logic        csr_wr;
   logic [7:0]  csr_wdata;
   logic [7:0]  csr_rdata;
   logic        spm;
   logic        lpm;
   logic [16:0] pointer;
   logic [15:0] store_data;
   logic        global_irq;
   logic        load_hit;
   logic [7:0]  load_data;
   logic        halt;
   logic        ready_irq;

   modport dev (
      input  csr_wr, csr_wdata, spm, lpm, pointer, store_data, global_irq,
      output csr_rdata, load_hit, load_data, halt, ready_irq
   );
   modport core (
      output csr_wr, csr_wdata, spm, lpm, pointer, store_data, global_irq,
      input  csr_rdata, load_hit, load_data, halt, ready_irq
   );
endinterface : boot_prog_if

// file: boot_prog_ctrl.sv
// self-programming controller: the flash end of the link
`timescale 1ns/1ps
module boot_prog_ctrl
   import boot_prog_pkg::*;
#(
   parameter int unsigned PROG_CYCLES = PROG_CYCLES_MIN
)(
   input  wire logic         clk_in,
   input  wire logic         rst_in,
   input  wire logic [1:0]   boot_size_in,
   input  wire logic [7:0]   fuse_low_in,
   input  wire logic [7:0]   fuse_high_in,
   input  wire logic [7:0]   fuse_ext_in,
   input  wire logic [6:0]   buf_idx_in,
   output logic [15:0]       boot_start_out,
   output logic              rww_read_enable_out,
   output logic              flash_erase_out,
   output logic              flash_write_out,
   output logic [8:0]        flash_page_out,
   output logic [15:0]       buf_word_out,
   output logic [7:0]        lock_bits_out,
   boot_prog_if.dev          link
);
   // -----------------------------------------------------------------
   // command decode
   // -----------------------------------------------------------------
   seq_state_t            state_r;
   logic [4:0]            cmd_r;
   logic [2:0]            win_r;
   logic [OP_CNT_W-1:0]   op_cnt_r;
   logic                  irq_en_r;
   logic                  rww_busy_r;
   logic                  halt_r;
   logic                  loading_r;
   logic [7:0]            lock_r;
   logic                  load_hit_r;
   logic [7:0]            load_data_r;
   logic [8:0]            page_r;
   logic                  erase_r;
   logic                  write_r;
   logic [15:0]           boot_start_r;
   logic [15:0]           buf_word_r;
   logic [15:0]           buf_r [PAGE_WORDS];
   logic                  cmd_ok;
   logic                  exec;
   logic                  do_fill;
   logic                  do_prog;
   logic                  do_lock;
   logic                  do_reen;
   logic                  do_load;
   logic                  abort;
   logic                  page_rww;
   logic [8:0]            z_page;
   logic [6:0]            z_word;

   assign z_page   = link.pointer[16:8];
   assign z_word   = link.pointer[7:1];
   assign page_rww = (z_page < RWW_PAGES);
   assign cmd_ok   = (link.csr_wdata[4:0] == CMD_REENABLE)
                  || (link.csr_wdata[4:0] == CMD_LOCK_SET)
                  || (link.csr_wdata[4:0] == CMD_PAGE_WRITE)
                  || (link.csr_wdata[4:0] == CMD_PAGE_ERASE)
                  || (link.csr_wdata[4:0] == CMD_FILL);
   // a store counts only while a command is armed and its window is open
   assign exec    = (state_r == ST_ARMED) && link.spm && (win_r != 3'h0);
   assign do_fill = exec && (cmd_r == CMD_FILL);
   assign do_prog = exec && ((cmd_r == CMD_PAGE_WRITE)
                         || (cmd_r == CMD_PAGE_ERASE));
   assign do_lock = exec && (cmd_r == CMD_LOCK_SET);
   assign do_reen = exec && (cmd_r == CMD_REENABLE);
   // the load window is one cycle shorter than the store window
   assign do_load = (state_r == ST_ARMED) && link.lpm && (cmd_r == CMD_LOCK_SET)
                 && (win_r > (STORE_WIN - LOAD_WIN));
   assign abort   = link.csr_wr && link.csr_wdata[BIT_REENABLE] && loading_r;

   // -----------------------------------------------------------------
   // sequencer
   // -----------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state_r  <= ST_IDLE;
         cmd_r    <= CSR_RESET[4:0];
         win_r    <= 3'h0;
         op_cnt_r <= '0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (link.csr_wr && cmd_ok) begin
                  cmd_r   <= link.csr_wdata[4:0];
                  win_r   <= STORE_WIN;
                  state_r <= ST_ARMED;
               end
            end
            ST_ARMED: begin
               if (do_prog || do_lock) begin
                  // enable stays set for the whole timed operation
                  op_cnt_r <= OP_CNT_W'(PROG_CYCLES - 1);
                  state_r  <= ST_BUSY;
               end else if (exec || do_load || (win_r == 3'h1)) begin
                  cmd_r   <= CSR_RESET[4:0];
                  win_r   <= 3'h0;
                  state_r <= ST_IDLE;
               end else begin
                  win_r <= win_r - 3'h1;
               end
            end
            ST_BUSY: begin
               if (op_cnt_r == '0) begin
                  cmd_r   <= CSR_RESET[4:0];
                  win_r   <= 3'h0;
                  state_r <= ST_IDLE;
               end else begin
                  op_cnt_r <= op_cnt_r - 1'b1;
               end
            end
            default: begin
               cmd_r   <= CSR_RESET[4:0];
               win_r   <= 3'h0;
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // status bits
   // -----------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         irq_en_r <= 1'b0;
      end else if (link.csr_wr) begin
         irq_en_r <= link.csr_wdata[BIT_IRQ_EN];
      end
   end

   // reenable only arms while idle, so it never meets a running program
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rww_busy_r <= 1'b0;
      end else if (do_prog && page_rww) begin
         rww_busy_r <= 1'b1;
      end else if (do_reen || do_fill) begin
         rww_busy_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         halt_r <= 1'b0;
      end else if (do_prog && !page_rww) begin
         halt_r <= 1'b1;
      end else if ((state_r == ST_BUSY) && (op_cnt_r == '0)) begin
         halt_r <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // page buffer
   // -----------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         loading_r <= 1'b0;
      end else if (abort || (do_prog && (cmd_r == CMD_PAGE_WRITE))) begin
         loading_r <= 1'b0;
      end else if (do_fill) begin
         loading_r <= 1'b1;
      end
   end

   generate
      for (genvar i = 0; i < PAGE_WORDS; i++) begin : g_buf
         always_ff @(posedge clk_in) begin
            if (rst_in || abort) begin
               buf_r[i] <= ERASED_WORD;
            end else if (do_fill && (z_word == WORD_W'(i))) begin
               buf_r[i] <= link.store_data;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         buf_word_r <= ERASED_WORD;
      end else begin
         buf_word_r <= buf_r[buf_idx_in];
      end
   end

   // -----------------------------------------------------------------
   // flash strobes, lock bits and readback
   // -----------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         erase_r <= 1'b0;
         write_r <= 1'b0;
         page_r  <= '0;
      end else begin
         erase_r <= do_prog && (cmd_r == CMD_PAGE_ERASE);
         write_r <= do_prog && (cmd_r == CMD_PAGE_WRITE);
         if (do_prog) begin
            page_r <= z_page;
         end
      end
   end

   // programming can only clear bits; the two top bits are not lock bits
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         lock_r <= LOCK_RESET;
      end else if (do_lock) begin
         lock_r <= lock_r & (link.store_data[7:0] | LOCK_WR_MASK);
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         load_hit_r  <= 1'b0;
         load_data_r <= 8'h00;
      end else begin
         load_hit_r <= do_load;
         case (link.pointer[1:0])
            SEL_LOCK:      load_data_r <= lock_r;
            SEL_FUSE_LOW:  load_data_r <= fuse_low_in;
            SEL_FUSE_HIGH: load_data_r <= fuse_high_in;
            default:       load_data_r <= fuse_ext_in;
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         boot_start_r <= BOOT_START_512;
      end else begin
         case (boot_size_in)
            2'h3:    boot_start_r <= BOOT_START_512;
            2'h2:    boot_start_r <= BOOT_START_1024;
            2'h1:    boot_start_r <= BOOT_START_2048;
            default: boot_start_r <= BOOT_START_4096;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   assign link.csr_rdata = {irq_en_r, rww_busy_r, 1'b0, cmd_r[4:1], state_r != ST_IDLE};
   assign link.ready_irq = irq_en_r && link.global_irq && (state_r == ST_IDLE);
   assign link.halt      = halt_r;
   assign link.load_hit  = load_hit_r;
   assign link.load_data = load_data_r;
   assign rww_read_enable_out = !rww_busy_r;
   assign flash_erase_out     = erase_r;
   assign flash_write_out     = write_r;
   assign flash_page_out      = page_r;
   assign buf_word_out        = buf_word_r;
   assign lock_bits_out       = lock_r;
   assign boot_start_out      = boot_start_r;
endmodule : boot_prog_ctrl

// file: boot_prog_core.sv
// core end: turns software port orders into store/load traffic
`timescale 1ns/1ps
module boot_prog_core
   import boot_prog_pkg::*;
(
   input  wire logic         clk_in,
   input  wire logic         rst_in,
   input  wire logic [7:0]   addr_in,
   input  wire logic [31:0]  wdata_in,
   input  wire logic         wr_in,
   input  wire logic         rd_in,
   input  wire logic         eeprom_write_active_in,
   output logic [31:0]       rdata_out,
   output logic              ready_irq_out,
   boot_prog_if.core         link
);
   // -----------------------------------------------------------------
   // software registers
   // -----------------------------------------------------------------
   logic        csr_wr_r;
   logic [7:0]  csr_wdata_r;
   logic        spm_r;
   logic        lpm_r;
   logic [16:0] ptr_r;
   logic [15:0] data_r;
   logic        gie_r;
   logic [8:0]  result_r;
   logic        refused_r;
   logic [31:0] rdata_r;
   logic        blocked;
   logic        page_wr_armed;

   // no store or arm while eeprom busy or the core is halted
   assign blocked = eeprom_write_active_in || link.halt;
   assign page_wr_armed = link.csr_rdata[BIT_PAGE_WRITE];

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         csr_wr_r    <= 1'b0;
         csr_wdata_r <= CSR_RESET;
         spm_r       <= 1'b0;
         lpm_r       <= 1'b0;
         refused_r   <= 1'b0;
      end else begin
         csr_wr_r <= 1'b0;
         spm_r    <= 1'b0;
         lpm_r    <= 1'b0;
         if (wr_in && (addr_in == SW_CSR)) begin
            // arming is refused, not held, while program_enable is set
            if (blocked || link.csr_rdata[BIT_PROG_EN]) begin
               refused_r <= 1'b1;
            end else begin
               csr_wr_r    <= 1'b1;
               csr_wdata_r <= wdata_in[7:0];
            end
         end
         if (wr_in && (addr_in == SW_ISSUE)) begin
            if (blocked) begin
               refused_r <= 1'b1;
            end else begin
               spm_r <= wdata_in[0];
               lpm_r <= wdata_in[1];
            end
         end
         if (wr_in && (addr_in == SW_STATUS) && wdata_in[0]) begin
            refused_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ptr_r  <= '0;
         data_r <= '0;
         gie_r  <= 1'b0;
      end else if (wr_in) begin
         case (addr_in)
            SW_POINTER:     ptr_r[15:0] <= wdata_in[15:0];
            SW_EXT_POINTER: ptr_r[16]   <= wdata_in[0];
            SW_DATA:        data_r      <= wdata_in[15:0];
            SW_CORE_CTRL:   gie_r       <= wdata_in[0];
            default:        ptr_r       <= ptr_r;
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         result_r <= '0;
      end else if (link.load_hit) begin
         result_r <= {1'b1, link.load_data};
      end else if (lpm_r) begin
         result_r <= '0;
      end
   end

   // -----------------------------------------------------------------
   // read port: data one cycle after the strobe
   // -----------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rdata_r <= '0;
      end else if (rd_in) begin
         case (addr_in)
            SW_CSR:         rdata_r <= {24'h000000, link.csr_rdata};
            SW_POINTER:     rdata_r <= {16'h0000, ptr_r[15:0]};
            SW_EXT_POINTER: rdata_r <= {31'h00000000, ptr_r[16]};
            SW_DATA:        rdata_r <= {16'h0000, data_r};
            SW_LOAD_RESULT: rdata_r <= {23'h000000, result_r};
            SW_CORE_CTRL:   rdata_r <= {31'h00000000, gie_r};
            SW_STATUS:      rdata_r <= {28'h0000000, eeprom_write_active_in,
                                        link.ready_irq, link.halt, refused_r};
            default:        rdata_r <= '0;
         endcase
      end else begin
         rdata_r <= '0;
      end
   end

   // -----------------------------------------------------------------
   // link drive
   // -----------------------------------------------------------------
   assign link.csr_wr     = csr_wr_r;
   assign link.csr_wdata  = csr_wdata_r;
   assign link.spm        = spm_r;
   assign link.lpm        = lpm_r;
   // store commands always see bit 0 low; page write also word bits low
   assign link.pointer    = {ptr_r[16:8],
                             (spm_r && page_wr_armed) ? 7'h00 : ptr_r[7:1],
                             spm_r ? 1'b0 : ptr_r[0]};
   assign link.store_data = data_r;
   assign link.global_irq = gie_r;
   assign rdata_out       = rdata_r;
   assign ready_irq_out   = link.ready_irq;
endmodule : boot_prog_core

// file: boot_prog_assertions.sv
// concurrent checks on the link between core end and controller
`timescale 1ns/1ps
module boot_prog_assertions (
   input wire logic        clk_in,
   input wire logic        rst_in,
   input wire logic        csr_wr,
   input wire logic [7:0]  csr_wdata,
   input wire logic [7:0]  csr_rdata,
   input wire logic        spm,
   input wire logic        lpm,
   input wire logic [16:0] pointer,
   input wire logic        global_irq,
   input wire logic        load_hit,
   input wire logic        halt,
   input wire logic        ready_irq
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // ----------------------------------------------------------
   // sequences
   // ----------------------------------------------------------
   sequence s_idle_wr(c);
      csr_wr && !csr_rdata[0] && csr_wdata[4:0] == c;
   endsequence
   // page erase or page write taken by a store
   sequence s_prog;
      spm && csr_rdata[0] && (csr_rdata[1] || csr_rdata[2]);
   endsequence
   // ----------------------------------------------------------
   // properties
   // ----------------------------------------------------------
   property p_irq;
      ready_irq == (csr_rdata[7] && global_irq && !csr_rdata[0]);
   endproperty
   a_irq: assert property (p_irq) else $error("ready irq level wrong");
   property p_arm;
      csr_wr && !csr_rdata[0] && (csr_wdata[4:0] inside {5'h11, 5'h09, 5'h05, 5'h03, 5'h01})
         |=> csr_rdata[0];
   endproperty
   a_arm: assert property (p_arm) else $error("valid command not armed");
   property p_inval;
      csr_wr && !csr_rdata[0] && !(csr_wdata[4:0] inside {5'h11, 5'h09, 5'h05, 5'h03, 5'h01})
         |=> csr_rdata[4:0] == 5'h00;
   endproperty
   a_inval: assert property (p_inval) else $error("invalid command took effect");
   property p_window;
      s_idle_wr(5'h01) ##1 (!spm)[*4] |-> ##2 !csr_rdata[0];
   endproperty
   a_window: assert property (p_window) else $error("enable outlived window");
   property p_fill;
      spm && csr_rdata[4:0] == 5'h01 |=> !csr_rdata[0] && !csr_rdata[6];
   endproperty
   a_fill: assert property (p_fill) else $error("fill left enable or busy");
   property p_rww;
      s_prog and pointer[16:8] < 9'h1E0 |=> csr_rdata[6] && !halt;
   endproperty
   a_rww: assert property (p_rww) else $error("section busy not set");
   property p_blocking_section;
      s_prog and pointer[16:8] >= 9'h1E0 |=> halt ##1 csr_rdata[0][*4];
   endproperty
   a_blocking_section: assert property (p_blocking_section) else $error("core not halted");
   property p_reen;
      s_idle_wr(5'h11) ##[1:4] spm |=> ##1 !csr_rdata[6];
   endproperty
   a_reen: assert property (p_reen) else $error("reenable left busy");
   property p_readback;
      s_idle_wr(5'h09) ##[1:3] lpm |=> load_hit;
   endproperty
   a_readback: assert property (p_readback) else $error("no readback hit");
   property p_ptr;
      spm |-> !pointer[0];
   endproperty
   a_ptr: assert property (p_ptr) else $error("pointer bit 0 set on store");
   // the simulated program time is shortened, so the bound is short as well
   property p_halt_end;
      $rose(halt) |-> ##[1:20] !halt;
   endproperty
   a_halt_end: assert property (p_halt_end) else $error("halt too long");
endmodule : boot_prog_assertions

// file: testbench.sv
// self-checking bench joining core end and controller
`timescale 1ns/1ps
module testbench;
   import boot_prog_pkg::*;
   logic        clk_in, rst_in, wr_in, rd_in, rww_read_enable_out, ready_irq_out, ers, wrt;
   logic        ee_busy;
   logic [1:0]  boot_size_in;
   logic [6:0]  buf_idx_in;
   logic [7:0]  addr_in, lock_bits_out;
   logic [8:0]  flash_page_out;
   logic [15:0] boot_start_out, buf_word_out;
   logic [31:0] wdata_in, rdata_out;
   int          fails = 0, cmp_count = 0, n_ers = 0, n_wrt = 0;
   localparam logic [15:0] BOOT_TAB [4] = '{16'hF000, 16'hF800, 16'hFC00, 16'hFE00};
   localparam logic [7:0]  RD_TAB [4]   = '{8'hA5, 8'hFC, 8'hF3, 8'h5A};
   boot_prog_if link();
   boot_prog_ctrl #(.PROG_CYCLES(8)) i_boot_prog_ctrl (.clk_in, .rst_in, .boot_size_in,
      .fuse_low_in(8'hA5), .fuse_high_in(8'h5A), .fuse_ext_in(8'hF3), .buf_idx_in,
      .boot_start_out, .rww_read_enable_out, .flash_erase_out(ers), .flash_write_out(wrt),
      .flash_page_out, .buf_word_out, .lock_bits_out, .link(link));
   boot_prog_core i_boot_prog_core (.clk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
      .eeprom_write_active_in(ee_busy), .rdata_out, .ready_irq_out, .link(link));
   boot_prog_assertions u_chk (.clk_in, .rst_in, .csr_wr(link.csr_wr),
      .csr_wdata(link.csr_wdata), .csr_rdata(link.csr_rdata), .spm(link.spm), .lpm(link.lpm),
      .pointer(link.pointer), .global_irq(link.global_irq), .load_hit(link.load_hit),
      .halt(link.halt), .ready_irq(link.ready_irq));
   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      n_ers += int'(ers === 1'b1);
      n_wrt += int'(wrt === 1'b1);
   end
   task chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr_in  <= a;
      wdata_in <= d;
      wr_in    <= 1'b1;
      @(posedge clk_in);
      wr_in    <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_in);
      addr_in <= a;
      rd_in   <= 1'b1;
      @(posedge clk_in);
      rd_in   <= 1'b0;
      #1 chk(rdata_out, e);
   endtask : rd
   // pointer, data and command, then the store or load order right behind
   task op(input logic [16:0] p, input logic [15:0] d, input logic [4:0] c,
           input logic [1:0] iss);
      wr(SW_POINTER, {16'h0, p[15:0]});
      wr(SW_EXT_POINTER, {31'h0, p[16]});
      wr(SW_DATA, {16'h0, d});
      wr(SW_CSR, {27'h0, c});
      wr(SW_ISSUE, {30'h0, iss});
   endtask : op
   // long enough for the shortened program time to run out
   task idle;
      repeat (16) @(posedge clk_in);
      #1;
   endtask : idle
   task wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up
   initial begin
      repeat (5000) @(posedge clk_in);
      fails++;
      wrap_up();
   end
   initial begin
      {rst_in, wr_in, rd_in, addr_in, wdata_in, buf_idx_in, boot_size_in} = '1;
      {wr_in, rd_in, ee_busy} = 3'h0;
      repeat (10) @(posedge clk_in);
      rst_in <= 1'b0;
      rd(SW_CSR, 32'h0);
      for (int s = 0; s < 4; s++) begin
         boot_size_in <= s[1:0];
         repeat (2) @(posedge clk_in);
         #1 chk(boot_start_out, {16'h0, BOOT_TAB[s]});
      end
      op(17'h0000A, 16'h1234, CMD_FILL, 2'h1);
      buf_idx_in <= 7'h05;
      repeat (2) @(posedge clk_in);
      #1 chk(buf_word_out, 32'h1234);
      op(17'h00300, 16'h0, CMD_PAGE_ERASE, 2'h1);
      repeat (2) @(posedge clk_in);
      #1 chk(rww_read_enable_out, 32'h0);
      idle();
      chk(flash_page_out, 32'h003);
      chk(n_ers, 32'h1);
      op(17'h0, 16'h0, CMD_REENABLE, 2'h1);
      idle();
      chk(rww_read_enable_out, 32'h1);
      chk(buf_word_out, 32'hFFFF);
      op(17'h1F000, 16'h0, CMD_PAGE_WRITE, 2'h1);
      repeat (2) @(posedge clk_in);
      #1 chk(link.halt, 32'h1);
      idle();
      chk(flash_page_out, 32'h1F0);
      chk(n_wrt, 32'h1);
      op(17'h0, 16'h003C, CMD_LOCK_SET, 2'h1);
      idle();
      chk(lock_bits_out, 32'hFC);
      for (int s = 0; s < 4; s++) begin
         op({15'h0, s[1:0]}, 16'h0, CMD_LOCK_SET, 2'h2);
         idle();
         rd(SW_LOAD_RESULT, {23'h0, 1'b1, RD_TAB[s]});
      end
      wr(SW_CSR, 32'h01);
      idle();
      rd(SW_CSR, 32'h0);
      wr(SW_CSR, 32'h06);
      idle();
      rd(SW_CSR, 32'h0);
      // a busy eeprom must stop the arm and leave the sticky refusal bit
      ee_busy <= 1'b1;
      wr(SW_CSR, 32'h01);
      rd(SW_CSR, 32'h0);
      rd(SW_STATUS, 32'h9);
      ee_busy <= 1'b0;
      wr(SW_STATUS, 32'h1);
      rd(SW_STATUS, 32'h0);
      wr(SW_CORE_CTRL, 32'h1);
      wr(SW_CSR, 32'h80);
      repeat (2) @(posedge clk_in);
      #1 chk(ready_irq_out, 32'h1);
      wr(SW_CSR, 32'h81);
      repeat (2) @(posedge clk_in);
      #1 chk(ready_irq_out, 32'h0);
      wrap_up();
   end
endmodule : testbench
